//--- design/adcsq_consts.vh
`ifndef ADCSQ_CONSTS_VH
`define ADCSQ_CONSTS_VH
// register offsets (byte addresses, 16-bit address space)
`define ADCSQ_OFF_RESULT_LO 16'h1faa
`define ADCSQ_OFF_RESULT_HI 16'h1fab
`define ADCSQ_OFF_COMMAND   16'h1fac
`define ADCSQ_OFF_TEST      16'h1fae
`define ADCSQ_OFF_TIMING    16'h1faf
// reset values
`define ADCSQ_RST_RESULT    16'h7f80
`define ADCSQ_RST_COMMAND   8'hc0
`define ADCSQ_RST_TEST      8'hc0
`define ADCSQ_RST_TIMING    8'hff
// test register fields
`define ADCSQ_TEST_EN_BIT   0
`define ADCSQ_TEST_SEL_BIT  1
`define ADCSQ_TRIM_MSB      3
`define ADCSQ_TRIM_LSB      2
// timing register fields
`define ADCSQ_SAM_MSB       7
`define ADCSQ_SAM_LSB       5
`define ADCSQ_BIT_MSB       4
`define ADCSQ_BIT_LSB       0
// command register fields
`define ADCSQ_MODE_MSB      5
`define ADCSQ_MODE_LSB      4
`define ADCSQ_GO_BIT        3
`define ADCSQ_CH_MSB        2
`define ADCSQ_CH_LSB        0
// modes
`define ADCSQ_MODE_10B      2'h0
`define ADCSQ_MODE_8B       2'h1
`define ADCSQ_MODE_THR_HI   2'h2
`define ADCSQ_MODE_THR_LO   2'h3
// timing: immediate start within three state times; busy within 8
`define ADCSQ_START_DELAY   4'h2
`define ADCSQ_SETTLE_CYC    5'h03
`endif

//--- design/adcsq_ctrl.v
`timescale 1ns/10ps
`include "adcsq_consts.vh"
// What this block does
// - test enable set converts a test voltage instead of the selected channel.
// - test select picks reference supply (1) or analog ground (0).
// - two-bit trim: none, +2.5 mV, -2.5 mV, -5.0 mV.
// - trim drives the ladder, so it applies to every channel.
// - threshold mode flags interrupt when input crosses above or below level.
// - sample window field sets how long input is connected to capacitor.
// - bit time field sets per-bit time, conversion about ((v+1)*2*bits+3).
// - mode field: 10-bit, 8-bit, threshold high, threshold low.
// - in 10-bit and 8-bit modes any write of the trigger bit arms; 1 starts now, 0 waits for event.
// - channel field picks one of eight analog inputs.
// - new command write cancels threshold detection and runs the new command.
// - conversion completion sets the interrupt pending bit.
// - the interrupt may launch the next conversion via the transaction server.
// - starting a conversion clears the whole result register.
// - read view holds value in bits 15:6, msb at 15.
// - result is input over reference scaled to 255 or 1023.
// - command-started conversion begins within three state times.
// - busy flag at read bit 3, set within 8 state times of start.
// - binary search from half scale, one bit per step, 10 or 8 steps.
module adcsq_ctrl #(
  parameter NCH = 8
) (
  input  wire        ref_clk,
  input  wire        arst_n,
  input  wire        clk_en,
  input  wire [15:0] reg_addr,
  input  wire [7:0]  reg_wdata,
  input  wire        reg_wr,
  input  wire        reg_rd,
  output reg  [7:0]  reg_rdata,
  input  wire        event_trigger,
  input  wire        cmp_above,
  output reg  [2:0]  mux_select,
  output reg         mux_test,
  output reg         mux_test_ref,
  output reg         sample_connect,
  output reg         cmp_zero,
  output reg  [9:0]  dac_code,
  output reg  [2:0]  ladder_offset,
  output reg         eight_bit_mode,
  output reg         interrupt_pending
);
  localparam ST_IDLE  = 3'h0;
  localparam ST_ARMED = 3'h1;
  localparam ST_DELAY = 3'h2;
  localparam ST_SAMP  = 3'h3;
  localparam ST_ZERO  = 3'h4;
  localparam ST_BIT   = 3'h5;
  localparam ST_THR   = 3'h6;

  reg  [15:0] result_q;
  reg  [7:0]  command_q;
  reg  [7:0]  test_q;
  reg  [7:0]  timing_q;
  reg  [2:0]  state_q;
  reg  [9:0]  sar_q;
  reg  [3:0]  bit_idx_q;
  reg  [2:0]  last_ch_q;
  reg         busy_q;
  reg         thr_prev_q;
  reg         tmr_load;
  reg  [7:0]  tmr_val;
  wire        tmr_done;
  wire [2:0]  trim_off;
  wire [1:0]  mode       = command_q[`ADCSQ_MODE_MSB:`ADCSQ_MODE_LSB];
  wire        cmd_wr     = reg_wr && (reg_addr == `ADCSQ_OFF_COMMAND);
  // 8-bit search stops at ladder bit 2, so the dac keeps one 10-bit scale in every mode
  wire [3:0]  last_idx   = (mode == `ADCSQ_MODE_10B) ? 4'h0 : 4'h2;
  // per-bit time of (v+1)*2+1 cycles; counter counts load value plus one, reload takes one more
  wire [7:0]  bit_load   = {2'b00, timing_q[`ADCSQ_BIT_MSB:`ADCSQ_BIT_LSB], 1'b0} + 8'h01;
  wire [7:0]  samp_load  = {5'h00, timing_q[`ADCSQ_SAM_MSB:`ADCSQ_SAM_LSB]} + 8'h01;

  adcsq_timer #(.W(8)) u_timer (
    .ref_clk  (ref_clk),
    .arst_n   (arst_n),
    .clk_en   (clk_en),
    .load     (tmr_load),
    .load_val (tmr_val),
    .done     (tmr_done)
  );

  adcsq_trim u_trim (
    .trim_code     (test_q[`ADCSQ_TRIM_MSB:`ADCSQ_TRIM_LSB]),
    .ladder_offset (trim_off)
  );

  // timer loads launched combinationally from the sequencer state
  always @* begin
    tmr_load = 1'b0;
    tmr_val  = 8'h00;
    if (clk_en) begin
      case (state_q)
        ST_IDLE, ST_ARMED, ST_THR: begin
          tmr_load = cmd_wr && reg_wdata[`ADCSQ_GO_BIT] && !reg_wdata[`ADCSQ_MODE_MSB];
          tmr_val  = {4'h0, `ADCSQ_START_DELAY};
          if (state_q == ST_ARMED && event_trigger && !cmd_wr) begin
            tmr_load = 1'b1;
          end
        end
        ST_DELAY: begin
          tmr_load = tmr_done;
          tmr_val  = samp_load;
        end
        ST_SAMP: begin
          tmr_load = tmr_done;
          tmr_val  = {3'h0, `ADCSQ_SETTLE_CYC};
        end
        ST_ZERO, ST_BIT: begin
          tmr_load = tmr_done;
          tmr_val  = bit_load;
        end
        default: begin
          tmr_load = 1'b0;
          tmr_val  = 8'h00;
        end
      endcase
      // a command write with the go bit set restarts timing below, except threshold modes which run untimed
      if (cmd_wr && state_q != ST_IDLE && state_q != ST_ARMED && state_q != ST_THR) begin
        tmr_load = reg_wdata[`ADCSQ_GO_BIT] && !reg_wdata[`ADCSQ_MODE_MSB];
        tmr_val  = {4'h0, `ADCSQ_START_DELAY};
      end
    end
  end

  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      result_q          <= `ADCSQ_RST_RESULT;
      command_q         <= `ADCSQ_RST_COMMAND;
      test_q            <= `ADCSQ_RST_TEST;
      timing_q          <= `ADCSQ_RST_TIMING;
      state_q           <= ST_IDLE;
      sar_q             <= 10'h000;
      bit_idx_q         <= 4'h0;
      last_ch_q         <= 3'h0;
      busy_q            <= 1'b0;
      thr_prev_q        <= 1'b0;
      reg_rdata         <= 8'h00;
      mux_select        <= 3'h0;
      mux_test          <= 1'b0;
      mux_test_ref      <= 1'b0;
      sample_connect    <= 1'b0;
      cmp_zero          <= 1'b0;
      dac_code          <= 10'h000;
      ladder_offset     <= 3'h0;
      eight_bit_mode    <= 1'b0;
      interrupt_pending <= 1'b0;
    end else if (clk_en) begin
      interrupt_pending <= 1'b0;
      ladder_offset     <= trim_off;
      mux_test          <= test_q[`ADCSQ_TEST_EN_BIT];
      mux_test_ref      <= test_q[`ADCSQ_TEST_SEL_BIT];
      mux_select        <= command_q[`ADCSQ_CH_MSB:`ADCSQ_CH_LSB];
      eight_bit_mode    <= (mode != `ADCSQ_MODE_10B);
      if (reg_rd) begin
        case (reg_addr)
          `ADCSQ_OFF_RESULT_LO: reg_rdata <= {result_q[7:4], busy_q, last_ch_q};
          `ADCSQ_OFF_RESULT_HI: reg_rdata <= result_q[15:8];
          `ADCSQ_OFF_COMMAND:   reg_rdata <= command_q;
          `ADCSQ_OFF_TEST:      reg_rdata <= test_q;
          `ADCSQ_OFF_TIMING:    reg_rdata <= timing_q;
          default:              reg_rdata <= 8'h00;
        endcase
      end
      if (reg_wr) begin
        case (reg_addr)
          `ADCSQ_OFF_RESULT_HI: result_q[15:8] <= reg_wdata;          // threshold level
          `ADCSQ_OFF_RESULT_LO: result_q[7:0]  <= reg_wdata;
          `ADCSQ_OFF_TEST:      test_q   <= {4'h0, reg_wdata[3:0]};
          `ADCSQ_OFF_TIMING:    timing_q <= reg_wdata;
          default: ;
        endcase
      end
      case (state_q)
        ST_ARMED: begin
          if (event_trigger) begin
            state_q  <= ST_DELAY;
            busy_q   <= 1'b1;
            result_q <= 16'h0000;
            sar_q    <= 10'h000;
          end
        end
        ST_DELAY: begin
          if (tmr_done) begin
            state_q        <= ST_SAMP;
            sample_connect <= 1'b1;
          end
        end
        ST_SAMP: begin
          if (tmr_done) begin
            state_q        <= ST_ZERO;
            sample_connect <= 1'b0;
            cmp_zero       <= 1'b1;
          end
        end
        ST_ZERO: begin
          if (tmr_done) begin
            state_q   <= ST_BIT;
            cmp_zero  <= 1'b0;
            bit_idx_q <= 4'h9;
            dac_code  <= 10'h200;
          end
        end
        ST_BIT: begin
          if (tmr_done) begin
            sar_q[bit_idx_q] <= cmp_above;
            if (bit_idx_q == last_idx) begin
              state_q           <= ST_IDLE;
              busy_q            <= 1'b0;
              interrupt_pending <= 1'b1;
              last_ch_q         <= command_q[`ADCSQ_CH_MSB:`ADCSQ_CH_LSB];
              // 8-bit result left-aligned, full scale 255 or 1023
              result_q[15:6]    <= (mode == `ADCSQ_MODE_10B) ?
                                   {sar_q[9:1], cmp_above} : {sar_q[9:3], cmp_above, 2'b00};
              result_q[5:0]     <= 6'h00;
            end else begin
              bit_idx_q <= bit_idx_q - 4'h1;
              dac_code  <= (sar_q | ({9'h000, cmp_above} << bit_idx_q)) | (10'h001 << (bit_idx_q - 4'h1));
            end
          end
        end
        ST_THR: begin
          dac_code       <= {result_q[15:8], 2'b00};
          sample_connect <= 1'b1;
          thr_prev_q     <= cmp_above;
          // crossing seen as a change of comparator side in the armed direction
          if ((mode == `ADCSQ_MODE_THR_HI && cmp_above && !thr_prev_q) ||
              (mode == `ADCSQ_MODE_THR_LO && !cmp_above && thr_prev_q)) begin
            interrupt_pending <= 1'b1;
          end
        end
        default: ;
      endcase
      // any command write cancels whatever runs and takes the new command
      if (cmd_wr) begin
        command_q      <= {2'b00, reg_wdata[5:0]};
        sample_connect <= 1'b0;
        cmp_zero       <= 1'b0;
        if (reg_wdata[`ADCSQ_MODE_MSB]) begin
          state_q    <= ST_THR;
          busy_q     <= 1'b0;
          thr_prev_q <= !reg_wdata[`ADCSQ_MODE_LSB];
        end else if (reg_wdata[`ADCSQ_GO_BIT]) begin
          state_q  <= ST_DELAY;
          busy_q   <= 1'b1;
          result_q <= 16'h0000;
          sar_q    <= 10'h000;
        end else begin
          state_q <= ST_ARMED;
          busy_q  <= 1'b0;
        end
      end
    end
  end
endmodule

//--- design/adcsq_timer.v
`timescale 1ns/10ps
// reloadable down counter; done pulses when count reaches zero
module adcsq_timer #(
  parameter W = 8
) (
  input  wire         ref_clk,
  input  wire         arst_n,
  input  wire         clk_en,
  input  wire         load,
  input  wire [W-1:0] load_val,
  output reg          done
);
  reg [W-1:0] cnt_q;
  reg         run_q;
  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt_q <= {W{1'b0}};
      run_q <= 1'b0;
      done  <= 1'b0;
    end else if (clk_en) begin
      done <= 1'b0;
      if (load) begin
        cnt_q <= load_val;
        run_q <= 1'b1;
      end else if (run_q) begin
        if (cnt_q == {W{1'b0}}) begin
          run_q <= 1'b0;
          done  <= 1'b1;
        end else begin
          cnt_q <= cnt_q - {{(W-1){1'b0}}, 1'b1};
        end
      end
    end
  end
endmodule

//--- design/adcsq_trim.v
`timescale 1ns/10ps
// maps trim code to a signed ladder offset in 2.5 mV steps (three-bit, 0.25 lsb10 units)
module adcsq_trim (
  input  wire [1:0] trim_code,
  output reg  [2:0] ladder_offset
);
  always @* begin
    case (trim_code)
      2'h1:    ladder_offset = 3'h1;  // +2.5 mV
      2'h2:    ladder_offset = 3'h7;  // -2.5 mV
      2'h3:    ladder_offset = 3'h6;  // -5.0 mV
      default: ladder_offset = 3'h0;
    endcase
  end
endmodule

//--- tb/adc_sequencer_control_tb.sv
`timescale 1ns/10ps
module adc_sequencer_control_tb;
  reg         ref_clk = 1'b0, arst_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
  reg         event_trigger = 1'b0, cmp_above = 1'b0;
  reg  [15:0] reg_addr = 16'h0000;
  reg  [7:0]  reg_wdata = 8'h00, d;
  reg  [9:0]  chv [0:7];
  reg  [9:0]  v;
  reg  [31:0] seed = 32'h0000_3de6;
  integer     fails = 0, n_checks = 0, irqs = 0, cyc = 0, i, t;
  wire [7:0]  reg_rdata;
  wire [9:0]  dac_code;
  wire [2:0]  mux_select, ladder_offset;
  wire        mux_test, mux_test_ref, sample_connect, cmp_zero, eight_bit_mode, interrupt_pending;
  // test sources are full scale or ground
  wire [9:0]  vin = mux_test ? {10{mux_test_ref}} : chv[mux_select];
  adcsq_ctrl #(.NCH(8)) dut (
    .ref_clk, .arst_n, .clk_en(1'b1), .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .event_trigger, .cmp_above, .mux_select, .mux_test, .mux_test_ref, .sample_connect,
    .cmp_zero, .dac_code, .ladder_offset, .eight_bit_mode, .interrupt_pending
  );
  always #12.5 ref_clk = ~ref_clk;
  always @(posedge ref_clk) begin
    cmp_above <= vin >= dac_code;
    if (interrupt_pending === 1'b1) irqs = irqs + 1;
    cyc = cyc + 1;
    if (cyc > 30000) begin
      fails = fails + 1;
      $display("mismatch at %0t: timeout", $time);
      end_sim;
    end
  end
  function [31:0] lfsr(input [31:0] s);
    lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task chk(input [15:0] got, input [15:0] exp);
    begin
      n_checks = n_checks + 1;
      if (got !== exp) begin
        fails = fails + 1;
        $display("mismatch at %0t: got %h exp %h", $time, got, exp);
      end
    end
  endtask
  task wr(input [15:0] a, input [7:0] x);
    begin
      reg_addr <= a;
      reg_wdata <= x;
      reg_wr <= 1'b1;
      @(posedge ref_clk);
      reg_wr <= 1'b0;
      @(posedge ref_clk);
    end
  endtask
  task rd(input [15:0] a, output [7:0] x);
    begin
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge ref_clk);
      reg_rd <= 1'b0;
      #1 x = reg_rdata;
      @(posedge ref_clk);
    end
  endtask
  task wait_irq(input integer n);
    integer k, i0;
    begin
      i0 = irqs;
      for (k = 0; k < n && irqs == i0; k = k + 1) @(posedge ref_clk);
      chk(irqs - i0, 1);
    end
  endtask
  // ev: command only arms, the event strobe starts it
  task conv(input [7:0] cmd, input [9:0] x, input ev);
    reg [7:0] lo, hi;
    integer i0;
    begin
      wr(16'h1fac, cmd);
      if (ev) begin
        i0 = irqs;
        repeat (20) @(posedge ref_clk);
        rd(16'h1faa, lo);
        chk(lo[3], 1'b0);
        chk(irqs - i0, 0);
        event_trigger <= 1'b1;
        @(posedge ref_clk);
        event_trigger <= 1'b0;
      end
      repeat (6) @(posedge ref_clk);
      rd(16'h1faa, lo);
      rd(16'h1fab, hi);
      chk(lo[3], 1'b1);
      chk(hi, 8'h00);
      wait_irq(1500);
      rd(16'h1fab, hi);
      rd(16'h1faa, lo);
      if (cmd[4]) chk({hi, lo[3:0]}, {x[9:2], 1'b0, cmd[2:0]});
      else chk({hi, lo}, {x, 3'h0, cmd[2:0]});
    end
  endtask
  task end_sim;
    begin
      $display("checks %0d mismatches %0d", n_checks, fails);
      if (fails == 0 && n_checks > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
    end
  endtask
  initial begin
    for (i = 0; i < 8; i = i + 1) chv[i] = 10'h000;
    repeat (8) @(posedge ref_clk);
    arst_n <= 1'b1;
    @(posedge ref_clk);
    rd(16'h1faa, d);
    chk(d, 8'h80);
    rd(16'h1fab, d);
    chk(d, 8'h7f);
    rd(16'h1faf, d);
    chk(d, 8'hff);
    rd(16'h1fac, d);
    chk(d[5:0], 6'h00);
    rd(16'h1fad, d);
    chk(d, 8'h00);
    $display("test reset done");
    wr(16'h1faf, 8'h22);
    for (t = 0; t < 4; t = t + 1) begin
      wr(16'h1fae, {4'h0, t[1:0], 2'h0});
      @(posedge ref_clk);
      chk(ladder_offset, (t == 0) ? 3'h0 : (t == 1) ? 3'h1 : (t == 2) ? 3'h7 : 3'h6);
    end
    for (t = 0; t < 2; t = t + 1) begin
      wr(16'h1fae, {6'h03, t[0], 1'b1});
      conv(8'h0b, {10{t[0]}}, 1'b0);
    end
    wr(16'h1fae, 8'h0c);
    $display("test source done");
    // odd passes are 8-bit, so keep the two lsbs clear there
    for (i = 0; i < 16; i = i + 1) begin
      seed = lfsr(seed);
      v = seed[9:0] & (i[0] ? 10'h3fc : 10'h3ff);
      chv[i[2:0]] <= v;
      conv({3'h0, i[0], ~i[3], i[2:0]}, v, i[3]);
    end
    chk(ladder_offset, 3'h6);
    $display("test convert done");
    for (t = 0; t < 2; t = t + 1) begin
      // start on the far side of the level so that a real crossing follows
      chv[2] <= t[0] ? 10'h3ff : 10'h000;
      wr(16'h1fab, 8'h40);
      wr(16'h1faa, 8'h00);
      wr(16'h1fac, {3'h1, t[0], 4'ha});
      i = irqs;
      repeat (20) @(posedge ref_clk);
      chk(irqs - i, 0);
      chv[2] <= t[0] ? 10'h000 : 10'h3ff;
      wait_irq(200);
    end
    v = 10'h154;
    chv[2] <= v;
    conv(8'h0a, v, 1'b0);
    i = irqs;
    chv[2] <= 10'h000;
    repeat (30) @(posedge ref_clk);
    chk(irqs - i, 0);
    $display("test threshold done");
    end_sim;
  end
endmodule

//--- tb/adcsq_ctrl_sva.sv
`timescale 1ns/10ps
module adcsq_ctrl_sva (
  input wire        ref_clk,
  input wire        arst_n,
  input wire        clk_en,
  input wire [15:0] reg_addr,
  input wire [7:0]  reg_wdata,
  input wire        reg_wr,
  input wire        reg_rd,
  input wire [7:0]  reg_rdata,
  input wire [2:0]  mux_select,
  input wire        mux_test,
  input wire        mux_test_ref,
  input wire        sample_connect,
  input wire [2:0]  ladder_offset,
  input wire        eight_bit_mode,
  input wire        interrupt_pending
);
  reg  [2:0] ch_q;
  reg  [1:0] md_q;
  reg  [3:0] ts_q;
  wire       cmd_wr = clk_en && reg_wr && reg_addr == 16'h1fac;
  wire       tst_wr = clk_en && reg_wr && reg_addr == 16'h1fae;
  // 1faa..1faf minus the command high byte
  wire       mapped = reg_addr[15:3] == 13'h03f5 && reg_addr[2:1] != 2'h0 && reg_addr[2:0] != 3'h5;
  wire [2:0] trim_exp = ts_q[3] ? (ts_q[2] ? 3'h6 : 3'h7) : {2'h0, ts_q[2]};
  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      ch_q <= 3'h0;
      md_q <= 2'h0;
      ts_q <= 4'h0;
    end else begin
      if (cmd_wr) begin
        ch_q <= reg_wdata[2:0];
        md_q <= reg_wdata[5:4];
      end
      if (tst_wr) ts_q <= reg_wdata[3:0];
    end
  end
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!arst_n);
  sequence go_now;
    cmd_wr && reg_wdata[3] && !reg_wdata[5];
  endsequence
  sequence bad_rd;
    clk_en && reg_rd && !mapped;
  endsequence
  unmap_zero_a: assert property (bad_rd |=> reg_rdata == 8'h00) else $error("unmapped read not zero");
  irq_single_a: assert property (interrupt_pending |=> !interrupt_pending) else $error("irq longer than one cycle");
  start_sample_a: assert property (go_now |-> ##[1:8] sample_connect) else $error("no sampling after start");
  conv_done_a: assert property (go_now |-> ##[8:1000] interrupt_pending) else $error("conversion never done");
  sample_chan_a: assert property (sample_connect && !mux_test |-> mux_select == ch_q) else $error("wrong channel");
  test_src_a: assert property (sample_connect |-> mux_test == ts_q[0] && (!ts_q[0] || mux_test_ref == ts_q[1]))
    else $error("wrong test source");
  width_sel_a: assert property (sample_connect && !md_q[1] |-> eight_bit_mode == md_q[0])
    else $error("wrong width");
  trim_map_a: assert property (tst_wr |-> ##2 ladder_offset == trim_exp) else $error("wrong ladder offset");
endmodule
bind adcsq_ctrl adcsq_ctrl_sva u_sva (
  .ref_clk, .arst_n, .clk_en, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .mux_select,
  .mux_test, .mux_test_ref, .sample_connect, .ladder_offset, .eight_bit_mode, .interrupt_pending
);
